/* dac_atten_pkg.sv */
// Constants shared by the attenuation and mute control block.
package dac_atten_pkg;

    // *****************************************************************
    // Serial control word layout.
    // *****************************************************************
    localparam int          word_bits     = 16;
    localparam int          rw_pos        = 15;
    localparam int          idx_hi        = 14;
    localparam int          idx_lo        = 8;
    localparam logic [4:0]  head_count    = 5'h08;
    localparam logic [4:0]  word_count    = 5'h10;

    // *****************************************************************
    // Register indices.
    // *****************************************************************
    localparam logic [6:0]  idx_att_last  = 7'h07;
    localparam logic [6:0]  idx_mute      = 7'h08;
    localparam logic [6:0]  idx_disable   = 7'h09;
    localparam logic [6:0]  idx_ctl       = 7'h0A;
    localparam logic [6:0]  idx_mode      = 7'h0C;

    // *****************************************************************
    // Reset values and field positions.
    // *****************************************************************
    localparam logic [7:0]  att_reset     = 8'hFF;
    localparam logic [7:0]  mute_reset    = 8'h00;
    localparam logic [7:0]  disable_reset = 8'h00;
    localparam logic [7:0]  ctl_reset     = 8'h00;
    localparam logic [7:0]  ctl_mask      = 8'h6F;
    localparam int          rolloff_pos   = 6;
    localparam int          ramp_pos      = 5;
    localparam int          clksrc_pos    = 3;
    localparam int          mode_pos      = 6;

    // *****************************************************************
    // Attenuation code mapping and ramp timing in sample periods.
    // *****************************************************************
    localparam logic [7:0]  silence_max   = 8'h0F;
    localparam logic [7:0]  silence_code  = 8'h00;
    localparam logic [7:0]  pcm_zero_db   = 8'hFF;
    localparam logic [7:0]  stream_zero_db = 8'hF3;
    localparam logic [4:0]  ramp_fast     = 5'h08;
    localparam logic [4:0]  ramp_slow     = 5'h10;

endpackage

/* att_ramp_stepper.sv */
// One channel attenuator that steps its level toward a target code.
`timescale 1ns/1ns
`default_nettype none
module att_ramp_stepper (
    // System.
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Control.
    input  wire logic       step_en,
    input  wire logic [7:0] target_code,
    input  wire logic       mute,
    // Applied level.
    output logic      [7:0] level_code
);

    logic [7:0] aim;
    logic [7:0] level_d;

    // Mute aims at full silence; release aims back at the programmed code.
    assign aim = mute ? dac_atten_pkg::silence_code : target_code;

    // One half-decibel step per step enable, never a jump.
    assign level_d = (level_code < aim) ? level_code + 8'h01 :
                     (level_code > aim) ? level_code - 8'h01 : level_code;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            level_code <= dac_atten_pkg::att_reset;
        end else if (step_en) begin
            level_code <= level_d;
        end
    end

endmodule
`default_nettype wire

/* dac_attenuation_mute_control.sv */
// Register bank, serial control port and attenuation ramps of an eight-channel converter.
`timescale 1ns/1ns
`default_nettype none
module dac_attenuation_mute_control (
    // System.
    input  wire logic            clock,
    input  wire logic            sys_rst,
    // Serial control port pins.
    input  wire logic            ctl_select_n,
    input  wire logic            ctl_clock,
    input  wire logic            ctl_data_in,
    output logic                 ctl_data_out,
    output logic                 ctl_data_out_en_n,
    // Audio framing pins.
    input  wire logic            pcm_frame_word_clock,
    input  wire logic            time_multiplexed_command_audio_mode,
    // Per-channel controls.
    output logic [7:0][7:0]      channel_attenuation_code,
    output logic [7:0][8:0]      channel_gain_half_db,
    output logic [7:0]           channel_silenced,
    output logic [7:0]           channel_output_disable_bit,
    // Global controls.
    output logic                 rolloff_select_bit,
    output logic                 ramp_rate_select_bit,
    output logic                 stream_clock_source_bit,
    output logic                 bitstream_mode_select
);

    localparam int channels = 8;

    typedef enum logic [1:0] {
        st_idle   = 2'b01,
        st_active = 2'b10
    } port_state_t;

    // *****************************************************************
    // Pin synchronisers.
    // *****************************************************************
    // Bit order: 0 select, 1 clock, 2 data, 3 word clock, 4 tdm strap.
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [4:0] sync3_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 5'h01;
            sync2_q <= 5'h01;
            sync3_q <= 5'h01;
        end else begin
            sync1_q <= {time_multiplexed_command_audio_mode, pcm_frame_word_clock,
                        ctl_data_in, ctl_clock, ctl_select_n};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic sel_fall;
    logic sel_rise;
    logic sck_rise;
    logic sck_fall;
    logic sdi;
    logic wclk_rise;
    logic wclk_edge;
    logic tdm_mode;

    assign sel_fall  = sync3_q[0] & ~sync2_q[0];
    assign sel_rise  = ~sync3_q[0] & sync2_q[0];
    assign sck_rise  = ~sync3_q[1] & sync2_q[1];
    assign sck_fall  = sync3_q[1] & ~sync2_q[1];
    assign sdi       = sync2_q[2];
    assign wclk_rise = ~sync3_q[3] & sync2_q[3];
    assign wclk_edge = sync3_q[3] ^ sync2_q[3];
    assign tdm_mode  = sync2_q[4];

    // *****************************************************************
    // Serial control port.
    // *****************************************************************
    port_state_t       state_q;
    port_state_t       state_d;
    logic [15:0]       shift_q;
    logic [4:0]        count_q;
    logic [7:0]        rd_shift_q;
    logic              rd_frame_q;
    logic              rd_slot;
    logic              head_done;
    logic              is_read;
    logic [6:0]        idx;
    logic [7:0]        wdata;
    logic              commit;
    logic [15:0]       shift_next;

    assign shift_next = {shift_q[14:0], sdi};
    assign head_done  = (state_q == st_active) && sck_rise
                        && (count_q == head_count_m1());
    assign is_read    = shift_q[dac_atten_pkg::rw_pos];
    assign idx        = shift_q[dac_atten_pkg::idx_hi:dac_atten_pkg::idx_lo];
    assign wdata      = shift_q[7:0];
    // A write is taken only when sixteen or more bits arrived before the select rose.
    assign commit     = (state_q == st_active) && sel_rise
                        && (count_q == dac_atten_pkg::word_count) && !is_read;
    // A read bit slot is a falling bit clock in the data half of a read frame.
    assign rd_slot    = sck_fall && rd_frame_q && count_q >= dac_atten_pkg::head_count
                        && count_q < dac_atten_pkg::word_count;

    function automatic logic [4:0] head_count_m1();
        head_count_m1 = dac_atten_pkg::head_count - 5'h01;
    endfunction

    function automatic logic is_att_idx(input logic [6:0] i);
        is_att_idx = i <= dac_atten_pkg::idx_att_last;
    endfunction

    // The port is active from a falling select until the select rises again.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            st_idle: begin
                if (sel_fall) begin
                    state_d = st_active;
                end
            end
            st_active: begin
                if (sel_rise) begin
                    state_d = st_idle;
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= st_idle;
            shift_q <= 16'h0000;
            count_q <= 5'h00;
        end else begin
            state_q <= state_d;
            if (sel_fall) begin
                count_q <= 5'h00;
            end else if (state_q == st_active && sck_rise
                         && count_q != dac_atten_pkg::word_count) begin
                shift_q <= shift_next;
                count_q <= count_q + 5'h01;
            end
        end
    end

    // Read data leaves on falling clock edges after the index byte. The direction
    // bit is latched once the index is in, since until the sixteenth bit the top of
    // the shift register still holds bits of the previous frame.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_frame_q        <= 1'b0;
            rd_shift_q        <= 8'h00;
            ctl_data_out      <= 1'b0;
            ctl_data_out_en_n <= 1'b1;
        end else if (state_q != st_active || sel_rise) begin
            rd_frame_q        <= 1'b0;
            ctl_data_out_en_n <= 1'b1;
        end else if (head_done) begin
            rd_frame_q <= shift_next[dac_atten_pkg::rw_pos - dac_atten_pkg::idx_lo];
            rd_shift_q <= read_mux(shift_next[dac_atten_pkg::idx_hi - dac_atten_pkg::idx_lo:0]);
        end else if (rd_slot) begin
            ctl_data_out      <= rd_shift_q[7];
            rd_shift_q        <= {rd_shift_q[6:0], 1'b0};
            ctl_data_out_en_n <= 1'b0;
        end
    end

    // *****************************************************************
    // Register bank.
    // *****************************************************************
    logic [7:0] att_q [channels];
    logic [7:0] mute_q;
    logic [7:0] disable_q;
    logic       disable_pending_q;
    logic [7:0] ctl_q;
    logic       mode_q;

    // Unmapped indices read as zero.
    function automatic logic [7:0] read_mux(input logic [6:0] i);
        read_mux = 8'h00;
        if (is_att_idx(i)) begin
            read_mux = att_q[i[2:0]];
        end else if (i == dac_atten_pkg::idx_mute) begin
            read_mux = mute_q;
        end else if (i == dac_atten_pkg::idx_disable) begin
            read_mux = disable_q;
        end else if (i == dac_atten_pkg::idx_ctl) begin
            read_mux = ctl_q;
        end else if (i == dac_atten_pkg::idx_mode) begin
            read_mux = {1'b0, mode_q, 6'h00};
        end
    endfunction

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < channels; c++) begin
                att_q[c] <= dac_atten_pkg::att_reset;
            end
        end else if (commit && is_att_idx(idx)) begin
            att_q[idx[2:0]] <= wdata;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mute_q <= dac_atten_pkg::mute_reset;
            ctl_q  <= dac_atten_pkg::ctl_reset;
            mode_q <= 1'b0;
        end else if (commit) begin
            if (idx == dac_atten_pkg::idx_mute) begin
                mute_q <= wdata;
            end
            if (idx == dac_atten_pkg::idx_ctl) begin
                ctl_q <= wdata & dac_atten_pkg::ctl_mask;
            end
            if (idx == dac_atten_pkg::idx_mode) begin
                mode_q <= wdata[dac_atten_pkg::mode_pos];
            end
        end
    end

    // Disable bits: a write in multiplexed mode waits for a frame clock edge.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            disable_q                  <= dac_atten_pkg::disable_reset;
            disable_pending_q          <= 1'b0;
            channel_output_disable_bit <= dac_atten_pkg::disable_reset;
        end else if (commit && idx == dac_atten_pkg::idx_disable) begin
            disable_q <= wdata;
            if (tdm_mode) begin
                disable_pending_q <= 1'b1;
            end else begin
                channel_output_disable_bit <= wdata;
            end
        end else if (disable_pending_q && wclk_edge) begin
            channel_output_disable_bit <= disable_q;
            disable_pending_q          <= 1'b0;
        end
    end

    // *****************************************************************
    // Ramp timing from the sample rate.
    // *****************************************************************
    logic [4:0] sample_cnt_q;
    logic       step_en_q;
    logic [4:0] interval;

    assign interval = ctl_q[dac_atten_pkg::ramp_pos] ? dac_atten_pkg::ramp_slow
                                                      : dac_atten_pkg::ramp_fast;

    // The sample counter runs free, so the first step after a write lands one to
    // interval samples later.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sample_cnt_q <= 5'h00;
            step_en_q    <= 1'b0;
        end else begin
            step_en_q <= 1'b0;
            if (wclk_rise) begin
                if (sample_cnt_q >= interval - 5'h01) begin
                    sample_cnt_q <= 5'h00;
                    step_en_q    <= 1'b1;
                end else begin
                    sample_cnt_q <= sample_cnt_q + 5'h01;
                end
            end
        end
    end

    // *****************************************************************
    // Channel attenuators and code mapping.
    // *****************************************************************
    // Gain in half-decibel units, two's complement.
    function automatic logic [8:0] gain_of(input logic [7:0] code, input logic stream);
        gain_of = {1'b0, code} - {1'b0, stream ? dac_atten_pkg::stream_zero_db
                                              : dac_atten_pkg::pcm_zero_db};
    endfunction

    // All channels step on one shared enable, so their ramps stay in lockstep.
    for (genvar c = 0; c < channels; c++) begin : g_chan
        att_ramp_stepper u_ramp (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .step_en     (step_en_q),
            .target_code (att_q[c]),
            .mute        (mute_q[c]),
            .level_code  (channel_attenuation_code[c])
        );

        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                channel_gain_half_db[c] <= 9'h000;
                channel_silenced[c]     <= 1'b0;
            end else begin
                channel_gain_half_db[c] <= gain_of(channel_attenuation_code[c], mode_q);
                channel_silenced[c]     <= channel_attenuation_code[c]
                                           <= dac_atten_pkg::silence_max;
            end
        end
    end

    // *****************************************************************
    // Global control outputs.
    // *****************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rolloff_select_bit      <= 1'b0;
            ramp_rate_select_bit    <= 1'b0;
            stream_clock_source_bit <= 1'b0;
            bitstream_mode_select   <= 1'b0;
        end else begin
            rolloff_select_bit      <= ctl_q[dac_atten_pkg::rolloff_pos] & ~mode_q;
            ramp_rate_select_bit    <= ctl_q[dac_atten_pkg::ramp_pos];
            stream_clock_source_bit <= ctl_q[dac_atten_pkg::clksrc_pos] & mode_q;
            bitstream_mode_select   <= mode_q;
        end
    end

endmodule
`default_nettype wire

/* dac_atten_assertions.sv */
// Port checker for the attenuation and mute control block.
`timescale 1ns/1ns
`default_nettype none
module dac_atten_assertions (
    // System.
    input wire logic            clock,
    input wire logic            sys_rst,
    // Pins.
    input wire logic            ctl_select_n,
    input wire logic            ctl_data_out_en_n,
    input wire logic            pcm_frame_word_clock,
    input wire logic            time_multiplexed_command_audio_mode,
    // Controls.
    input wire logic [7:0][7:0] channel_attenuation_code,
    input wire logic [7:0][8:0] channel_gain_half_db,
    input wire logic [7:0]      channel_silenced,
    input wire logic [7:0]      channel_output_disable_bit,
    input wire logic            rolloff_select_bit,
    input wire logic            ramp_rate_select_bit,
    input wire logic            stream_clock_source_bit,
    input wire logic            bitstream_mode_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // *****
    // Word clock rising edges counted between two steps of channel one.
    // *****
    // The top bit of the edge count sticks, so a long idle gap never wraps to zero.
    logic       wc_q;
    logic [7:0] c0_q;
    logic [7:0] edges_q;
    logic [3:0] since_q;
    logic       run_q;
    wire        rise  = pcm_frame_word_clock & ~wc_q;
    wire        moved = channel_attenuation_code[0] != c0_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wc_q    <= 1'b0;
            c0_q    <= 8'hFF;
            edges_q <= 8'h00;
            since_q <= 4'hF;
            run_q   <= 1'b0;
        end else begin
            wc_q    <= pcm_frame_word_clock;
            c0_q    <= channel_attenuation_code[0];
            edges_q <= moved ? {7'h00, rise} : (edges_q + {7'h00, rise}) | (edges_q & 8'h80);
            since_q <= (pcm_frame_word_clock != wc_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
            run_q   <= (run_q | moved) & (ramp_rate_select_bit == $past(ramp_rate_select_bit));
        end
    end
    AST_STEP_ONE:
        assert property ($changed(channel_attenuation_code[0]) |-> 8'(channel_attenuation_code[0]
            - $past(channel_attenuation_code[0])) inside {8'h01, 8'hFF})
        else $error("attenuator moved by more than one step");
    AST_STEP_GAP:
        assert property (moved && run_q && $stable(ramp_rate_select_bit) |-> edges_q != 8'h00
            && (ramp_rate_select_bit ? edges_q[3:0] == 4'h0 : edges_q[2:0] == 3'h0))
        else $error("step spacing is not the selected sample count");
    AST_SILENCE:
        assert property (channel_silenced[0] == ($past(channel_attenuation_code[0]) <= 8'h0F))
        else $error("silence flag disagrees with the applied code");
    AST_GAIN:
        assert property ($stable(bitstream_mode_select) |-> channel_gain_half_db[0] ==
            9'({1'b0, $past(channel_attenuation_code[0])}
            - (bitstream_mode_select ? 9'h0F3 : 9'h0FF)))
        else $error("gain disagrees with the applied code");
    // Two synchroniser stages put the update two cycles after the pin edge is seen.
    AST_DISABLE_FRAME:
        assert property (time_multiplexed_command_audio_mode
            && $changed(channel_output_disable_bit) |-> since_q == 4'h2)
        else $error("disable bits changed away from a word clock edge");
    AST_ROLLOFF_PCM:
        assert property (bitstream_mode_select && $past(bitstream_mode_select)
            |-> !rolloff_select_bit)
        else $error("rolloff select active in stream mode");
    AST_CLKSRC_STREAM:
        assert property (!bitstream_mode_select && !$past(bitstream_mode_select)
            |-> !stream_clock_source_bit)
        else $error("stream clock source active in PCM mode");
    AST_EN_RELEASE:
        assert property ($rose(ctl_select_n) |-> ##[1:6] ctl_data_out_en_n)
        else $error("read data driver not released after the frame");
endmodule
bind dac_attenuation_mute_control dac_atten_assertions i_chk (.clock, .sys_rst,
    .ctl_select_n, .ctl_data_out_en_n, .pcm_frame_word_clock,
    .time_multiplexed_command_audio_mode, .channel_attenuation_code,
    .channel_gain_half_db, .channel_silenced, .channel_output_disable_bit,
    .rolloff_select_bit, .ramp_rate_select_bit, .stream_clock_source_bit,
    .bitstream_mode_select);
`default_nettype wire

/* dac_ctl_host.sv */
// Host model that sends control frames of up to 16 bits on the serial port.
`timescale 1ns/1ns
`default_nettype none
module dac_ctl_host (
    // System.
    input  wire logic clock,
    // Serial port.
    output var logic  ctl_select_n,
    output var logic  ctl_clock,
    output var logic  ctl_data_in,
    input  wire logic ctl_data_out
);
    initial begin
        ctl_select_n = 1'b1;
        ctl_clock    = 1'b0;
        ctl_data_in  = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Sends the top n bits MSB first; read bits are taken just before each rise.
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        hold(1);
        ctl_select_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            ctl_clock   = 1'b0;
            ctl_data_in = w[i];
            hold(6);
            if (i < 8) begin
                rd[i] = ctl_data_out;
            end
            ctl_clock = 1'b1;
            hold(6);
        end
        ctl_clock = 1'b0;
        hold(6);
        ctl_select_n = 1'b1;
        ctl_data_in  = ~ctl_data_in;
        hold(8);
    endtask
endmodule
`default_nettype wire

/* tb_dac_attenuation_mute_control.sv */
// Self-checking bench for the attenuation and mute control block.
`timescale 1ns/1ns
`default_nettype none
module tb_dac_attenuation_mute_control;
    logic            clock;
    logic            sys_rst;
    logic            sel_n;
    logic            sclk;
    logic            sdi;
    logic            sdo;
    logic            sdo_en_n;
    logic            sdo_line;
    logic            wclk;
    logic            tdm;
    logic [7:0][7:0] code;
    logic [7:0][8:0] gain;
    logic [7:0]      sil;
    logic [7:0]      dis;
    logic            roll;
    logic            rate;
    logic            csrc;
    logic            mode;
    logic [7:0]      shadow [16];
    logic [7:0]      rd;
    logic [31:0]     seed;
    logic [6:0]      idx;
    int              error_cnt;
    int              comparisons;
    dac_attenuation_mute_control i_dut (.clock, .sys_rst, .ctl_select_n(sel_n),
        .ctl_clock(sclk), .ctl_data_in(sdi), .ctl_data_out(sdo), .ctl_data_out_en_n(sdo_en_n),
        .pcm_frame_word_clock(wclk), .time_multiplexed_command_audio_mode(tdm),
        .channel_attenuation_code(code), .channel_gain_half_db(gain),
        .channel_silenced(sil), .channel_output_disable_bit(dis),
        .rolloff_select_bit(roll), .ramp_rate_select_bit(rate),
        .stream_clock_source_bit(csrc), .bitstream_mode_select(mode));
    // A released data line shows the inverse of the last bit, so a missing enable fails reads.
    assign sdo_line = sdo_en_n ? ~sdo : sdo;
    dac_ctl_host i_host (.clock, .ctl_select_n(sel_n), .ctl_clock(sclk),
        .ctl_data_in(sdi), .ctl_data_out(sdo_line));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always begin
        repeat (4) @(negedge clock);
        wclk = ~wclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] exp_rd(input logic [6:0] i);
        return (i < 7'h10) ? shadow[i[3:0]] : 8'h00;
    endfunction
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        i_host.xfer({1'b0, i, d}, 16, rd);
        if (i <= 7'h09) shadow[i[3:0]] = d;
        else if (i == 7'h0A) shadow[10] = d & 8'h6F;
        else if (i == 7'h0C) shadow[12] = d & 8'h40;
    endtask
    task automatic rdchk(input logic [6:0] i);
        i_host.xfer({1'b1, i, 8'h00}, 16, rd);
        check({1'b0, rd}, {1'b0, exp_rd(i)});
    endtask
    task automatic outs;
        check({1'b0, dis}, {1'b0, shadow[9]});
        check({7'h00, roll, rate}, {7'h00, shadow[10][6] & ~shadow[12][6], shadow[10][5]});
        check({7'h00, csrc, mode}, {7'h00, shadow[10][3] & shadow[12][6], shadow[12][6]});
    endtask
    task automatic settle(input logic [7:0] c);
        int n;
        n = 0;
        while (code[0] !== c && n < 40000) begin
            @(negedge clock);
            n++;
        end
        repeat (2) @(negedge clock);
        check({1'b0, code[0]}, {1'b0, c});
        check({8'h00, sil[0]}, {8'h00, c <= 8'h0F});
        check(gain[0], {1'b0, c} - (shadow[12][6] ? 9'h0F3 : 9'h0FF));
    endtask
    task automatic close_out;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        // About twice the longest expected run of some forty thousand cycles.
        #320000;
        error_cnt++;
        close_out;
    end
    initial begin
        sys_rst = 1'b1;
        wclk = 1'b0;
        tdm = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        seed = 32'h0000_9B41;
        for (int i = 0; i < 16; i++) shadow[i] = (i < 8) ? 8'hFF : 8'h00;
        repeat (4) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        check({1'b0, code[7]}, 9'h0FF);
        check(gain[3], 9'h000);
        check({1'b0, sil | dis}, 9'h000);
        for (int i = 0; i < 17; i++) rdchk(7'(i));
        outs();
        repeat (24) begin
            seed = xs(seed);
            idx = (seed[3:0] == 4'hC) ? 7'h0D : {3'h0, seed[3:0]};
            wr(idx, (idx == 7'h0A) ? seed[15:8] & 8'h6F : seed[15:8]);
            rdchk(idx);
            outs();
        end
        i_host.xfer({1'b0, 7'h01, ~shadow[1]}, 15, rd);
        rdchk(7'h01);
        wr(7'h08, 8'h00);
        wr(7'h0A, 8'h00);
        wr(7'h00, 8'h10);
        settle(8'h10);
        wr(7'h00, 8'h0F);
        settle(8'h0F);
        wr(7'h00, 8'h14);
        settle(8'h14);
        wr(7'h08, 8'h01);
        settle(8'h00);
        wr(7'h08, 8'h00);
        settle(8'h14);
        wr(7'h0A, 8'h20);
        wr(7'h00, 8'h18);
        settle(8'h18);
        wr(7'h0A, 8'h68);
        wr(7'h0C, 8'h40);
        settle(8'h18);
        rdchk(7'h0C);
        outs();
        tdm = 1'b1;
        repeat (8) @(negedge clock);
        repeat (4) begin
            seed = xs(seed);
            wr(7'h09, seed[7:0]);
            repeat (12) @(negedge clock);
            outs();
        end
        close_out;
    end
endmodule
`default_nettype wire
